// *** rtl/jcbp_pkg.sv ***
// Constants, state codes and helpers for the test access port
package jcbp_pkg;
	localparam int PAIRS     = 8;
	localparam int OUT_W     = 8;
	localparam int IN_W      = 2;
	localparam int COL_OUT_W = PAIRS * OUT_W;
	localparam int PED_W     = PAIRS * IN_W;
	localparam int PAIR_W    = OUT_W + IN_W;
	localparam int IR_W      = 4;
	localparam int ID_W      = 32;
	localparam int CFG_LEN   = 240;
	localparam int CHAN_LEN  = 256;
	localparam int BSR_LEN   = PAIRS * PAIR_W + 4;
	// Boundary bit 0 sits next to TDO
	localparam int BSR_INJ   = 4 * PAIR_W;
	localparam int BSR_ECHO  = BSR_INJ + 1;
	localparam int BSR_CLK   = BSR_INJ + 2;
	localparam int BSR_SYNC  = BSR_INJ + 3;
	localparam int CFG_INJ_BIT = 0;
	localparam int MS_FIVE   = 5;

	localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
	localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
	localparam logic [IR_W-1:0] IR_IDCODE  = 4'h2;
	localparam logic [IR_W-1:0] IR_CONFIG  = 4'h4;
	localparam logic [IR_W-1:0] IR_CHANNEL = 4'h8;
	localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	// Arbitrary neutral identification value
	localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0a5c_3e01;

	typedef enum logic [3:0] {
		TAP_RESET    = 4'b1111,
		TAP_IDLE     = 4'b1100,
		TAP_SEL_DR   = 4'b0111,
		TAP_CAP_DR   = 4'b0110,
		TAP_SH_DR    = 4'b0010,
		TAP_EX1_DR   = 4'b0001,
		TAP_PAUSE_DR = 4'b0011,
		TAP_EX2_DR   = 4'b0000,
		TAP_UPD_DR   = 4'b0101,
		TAP_SEL_IR   = 4'b0100,
		TAP_CAP_IR   = 4'b1110,
		TAP_SH_IR    = 4'b1010,
		TAP_EX1_IR   = 4'b1001,
		TAP_PAUSE_IR = 4'b1011,
		TAP_EX2_IR   = 4'b1000,
		TAP_UPD_IR   = 4'b1101
	} jcbp_tap_t;

	// Low bit of a column pair's cells within the boundary chain
	function automatic int jcbp_pair_base(input int p);
		return (p >= 4) ? (7 - p) * PAIR_W : BSR_SYNC + 1 + (3 - p) * PAIR_W;
	endfunction

	function automatic jcbp_tap_t jcbp_tap_step(input jcbp_tap_t s,
		input logic ms);
		jcbp_tap_t n;
		n = s;
		unique case (s)
			TAP_RESET:    n = ms ? TAP_RESET  : TAP_IDLE;
			TAP_IDLE:     n = ms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   n = ms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   n = ms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:    n = ms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR:   n = ms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: n = ms ? TAP_EX2_DR : TAP_PAUSE_DR;
			TAP_EX2_DR:   n = ms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR:   n = ms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   n = ms ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR:   n = ms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:    n = ms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR:   n = ms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: n = ms ? TAP_EX2_IR : TAP_PAUSE_IR;
			TAP_EX2_IR:   n = ms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR:   n = ms ? TAP_SEL_DR : TAP_IDLE;
		endcase
		return n;
	endfunction
endpackage

// *** rtl/jcbp_chain.sv ***
// Generic capture and shift chain used for every test data register
`timescale 1ns/10ps
`default_nettype none
module jcbp_chain #(
	parameter int WIDTH   = 8,
	parameter bit MSB_OUT = 1'b0
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Control strobes
	input  wire logic             shift_en,
	input  wire logic             capture_en,
	// Data
	input  wire logic [WIDTH-1:0] capture_data,
	input  wire logic             serial_in,
	output logic      [WIDTH-1:0] chain,
	output logic                  serial_out
);
	logic [WIDTH-1:0] next_chain;

	always_comb
	begin
		next_chain = chain;
		if (capture_en)
			next_chain = capture_data;
		else if (shift_en)
		begin
			// Casts keep a one-stage chain free of empty part-selects
			if (MSB_OUT)
				next_chain = WIDTH'({chain, serial_in});
			else
				next_chain = WIDTH'({serial_in, chain} >> 1);
		end
	end

	// Only system reset clears contents; test reset never reaches here
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			chain <= '0;
		else
			chain <= next_chain;
	end

	assign serial_out = MSB_OUT ? chain[WIDTH-1] : chain[0];
endmodule
`default_nettype wire

// *** rtl/jcbp_port.sv ***
// Test access port with boundary, id, bypass and configuration chains
`timescale 1ns/10ps
`default_nettype none
module jcbp_port #(
	parameter int                         CHAN_BITS = jcbp_pkg::CHAN_LEN,
	parameter logic [jcbp_pkg::ID_W-1:0]  ID_CODE   = jcbp_pkg::ID_DEFAULT
) (
	// Clock and reset
	input  wire logic                               clk_sys,
	input  wire logic                               rst,
	// Serial test link
	input  wire logic                               test_clock,
	input  wire logic                               test_mode_select,
	input  wire logic                               test_data_in,
	input  wire logic                               test_reset_low,
	output logic                                    test_data_out,
	output logic                                    test_data_out_oe,
	// Core outputs and output pads
	input  wire logic [jcbp_pkg::COL_OUT_W-1:0]     core_column_out,
	input  wire logic                               core_echoed_fast_clock,
	output logic      [jcbp_pkg::COL_OUT_W-1:0]     column_out_bus,
	// Input pads and core inputs
	input  wire logic [jcbp_pkg::PED_W-1:0]         pedestal_in_bus,
	input  wire logic                               pad_fast_clock,
	input  wire logic                               pad_sync_reset,
	output logic      [jcbp_pkg::PED_W-1:0]         core_pedestal_in,
	output logic                                    test_inject_enable,
	// Configuration results
	output logic      [jcbp_pkg::CFG_LEN-1:0]       config_bits,
	output logic      [CHAN_BITS-1:0]               channel_chain,
	output logic                                    channel_chain_load
);
	import jcbp_pkg::*;

	logic [2:0] tck_s;
	logic [1:0] tms_s;
	logic [1:0] tdi_s;
	logic       tck_rise;
	logic       tck_fall;
	logic       tms;
	logic       tdi;
	jcbp_tap_t  tap_state;
	jcbp_tap_t  next_tap;

	// Link clock, mode and data pins pass two flops; third tck stage finds edges
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tck_s <= '0;
			tms_s <= 2'h3;
			tdi_s <= '0;
		end
		else
		begin
			tck_s <= {tck_s[1:0], test_clock};
			tms_s <= {tms_s[0], test_mode_select};
			tdi_s <= {tdi_s[0], test_data_in};
		end
	end

	assign tck_rise = tck_s[1] & ~tck_s[2];
	assign tck_fall = ~tck_s[1] & tck_s[2];
	assign tms      = tms_s[1];
	assign tdi      = tdi_s[1];

	always_comb
	begin
		next_tap = tap_state;
		if (tck_rise)
			next_tap = jcbp_tap_step(tap_state, tms);
	end

	always_ff @(posedge clk_sys or posedge rst or negedge test_reset_low)
	begin
		if (rst)
			tap_state <= TAP_RESET;
		else if (!test_reset_low)
			tap_state <= TAP_RESET;
		else
			tap_state <= next_tap;
	end

	// Instruction decode; anything undefined falls to bypass
	logic [IR_W-1:0] ir;
	logic sel_ext, sel_pre, sel_bsr, sel_id, sel_cfg, sel_chan, sel_byp;
	assign sel_ext  = (ir == IR_EXTEST);
	assign sel_pre  = (ir == IR_SAMPLE);
	assign sel_bsr  = sel_ext | sel_pre;
	assign sel_id   = (ir == IR_IDCODE);
	assign sel_cfg  = (ir == IR_CONFIG);
	assign sel_chan = (ir == IR_CHANNEL);
	assign sel_byp  = ~(sel_bsr | sel_id | sel_cfg | sel_chan);

	logic ir_cap, ir_shift, dr_cap, dr_shift_r, dr_shift_f;
	logic upd_ir_hit, upd_dr_hit;
	assign ir_cap     = tck_rise && tap_state == TAP_CAP_IR;
	assign ir_shift   = tck_rise && tap_state == TAP_SH_IR;
	assign dr_cap     = tck_rise && tap_state == TAP_CAP_DR;
	assign dr_shift_r = tck_rise && tap_state == TAP_SH_DR;
	assign dr_shift_f = tck_fall && tap_state == TAP_SH_DR;
	assign upd_ir_hit = tck_rise && next_tap == TAP_UPD_IR;
	assign upd_dr_hit = tck_rise && next_tap == TAP_UPD_DR;

	// Boundary capture vector; core and pad levels pass two flops
	logic [BSR_LEN-1:0] raw_vec, cap_s1, cap_s2;
	logic [BSR_LEN-1:0] bsr_upd;
	logic [COL_OUT_W-1:0] upd_col;
	logic [PED_W-1:0]     upd_ped;
	logic [CFG_LEN-1:0]   cfg_latch;

	for (genvar p = 0; p < PAIRS; p++)
	begin : g_pair
		localparam int B = jcbp_pair_base(p);
		assign raw_vec[B+:IN_W]         = pedestal_in_bus[p*IN_W+:IN_W];
		assign raw_vec[B+IN_W+:OUT_W]   = core_column_out[p*OUT_W+:OUT_W];
		assign upd_ped[p*IN_W+:IN_W]    = bsr_upd[B+:IN_W];
		assign upd_col[p*OUT_W+:OUT_W]  = bsr_upd[B+IN_W+:OUT_W];
	end
	assign raw_vec[BSR_INJ]  = cfg_latch[CFG_INJ_BIT];
	assign raw_vec[BSR_ECHO] = core_echoed_fast_clock;
	assign raw_vec[BSR_CLK]  = pad_fast_clock;
	assign raw_vec[BSR_SYNC] = pad_sync_reset;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cap_s1 <= '0;
			cap_s2 <= '0;
		end
		else
		begin
			cap_s1 <= raw_vec;
			cap_s2 <= cap_s1;
		end
	end

	// Chains
	logic [IR_W-1:0]     ir_chain;
	logic [BSR_LEN-1:0]  bsr_chain;
	logic [ID_W-1:0]     id_chain;
	logic [CFG_LEN-1:0]  cfg_chain;
	logic ir_out, bsr_out, id_out, byp_out, cfg_out, chan_out;

	jcbp_chain #(.WIDTH(IR_W), .MSB_OUT(1'b0)) u_ir (
		.clk_sys(clk_sys), .rst(rst), .shift_en(ir_shift),
		.capture_en(ir_cap), .capture_data(IR_CAPTURE), .serial_in(tdi),
		.chain(ir_chain), .serial_out(ir_out));
	jcbp_chain #(.WIDTH(BSR_LEN), .MSB_OUT(1'b0)) u_bsr (
		.clk_sys(clk_sys), .rst(rst), .shift_en(dr_shift_r && sel_bsr),
		.capture_en(dr_cap && sel_bsr), .capture_data(cap_s2),
		.serial_in(tdi), .chain(bsr_chain), .serial_out(bsr_out));
	jcbp_chain #(.WIDTH(ID_W), .MSB_OUT(1'b0)) u_id (
		.clk_sys(clk_sys), .rst(rst), .shift_en(dr_shift_r && sel_id),
		.capture_en(dr_cap && sel_id), .capture_data(ID_CODE),
		.serial_in(tdi), .chain(id_chain), .serial_out(id_out));
	jcbp_chain #(.WIDTH(1), .MSB_OUT(1'b0)) u_byp (
		.clk_sys(clk_sys), .rst(rst), .shift_en(dr_shift_r && sel_byp),
		.capture_en(dr_cap && sel_byp), .capture_data(1'b0),
		.serial_in(tdi), .chain(), .serial_out(byp_out));
	// Config and channel chains shift on falling edge, never capture
	jcbp_chain #(.WIDTH(CFG_LEN), .MSB_OUT(1'b1)) u_cfg (
		.clk_sys(clk_sys), .rst(rst), .shift_en(dr_shift_f && sel_cfg),
		.capture_en(1'b0), .capture_data({CFG_LEN{1'b0}}),
		.serial_in(tdi), .chain(cfg_chain), .serial_out(cfg_out));
	jcbp_chain #(.WIDTH(CHAN_BITS), .MSB_OUT(1'b1)) u_chan (
		.clk_sys(clk_sys), .rst(rst), .shift_en(dr_shift_f && sel_chan),
		.capture_en(1'b0), .capture_data({CHAN_BITS{1'b0}}),
		.serial_in(tdi), .chain(channel_chain), .serial_out(chan_out));

	// Control, update and pin registers
	logic next_ir_valid;
	logic [IR_W-1:0]    next_ir;
	logic [BSR_LEN-1:0] next_bsr_upd;
	logic [CFG_LEN-1:0] next_cfg_latch;
	logic next_tdo, next_tdo_oe, next_chan_load, next_inj;
	logic [COL_OUT_W-1:0] next_col;
	logic [PED_W-1:0]     next_ped;
	logic std_out;

	assign std_out = sel_bsr ? bsr_out : (sel_id ? id_out : byp_out);

	always_comb
	begin
		next_ir_valid  = 1'b0;
		next_ir        = ir;
		next_bsr_upd   = bsr_upd;
		next_cfg_latch = cfg_latch;
		next_tdo       = test_data_out;
		next_chan_load = 1'b0;
		if (tap_state == TAP_RESET)
			next_ir = IR_IDCODE;
		else if (upd_ir_hit)
			next_ir = ir_chain;
		if (upd_dr_hit && sel_bsr)
			next_bsr_upd = bsr_chain;
		if (upd_dr_hit && sel_cfg)
			next_cfg_latch = cfg_chain;
		if (upd_dr_hit && sel_chan)
			next_chan_load = 1'b1;
		// Standard registers change TDO on the falling edge
		if (tck_fall && tap_state == TAP_SH_IR)
			next_tdo = ir_out;
		else if (tck_fall && tap_state == TAP_SH_DR && !(sel_cfg || sel_chan))
			next_tdo = std_out;
		// Falling-edge chains present their bit on the rising edge
		else if (tck_rise && (tap_state == TAP_CAP_DR
			|| tap_state == TAP_SH_DR) && (sel_cfg || sel_chan))
			next_tdo = sel_cfg ? cfg_out : chan_out;
		next_tdo_oe = (tap_state == TAP_SH_DR) || (tap_state == TAP_SH_IR);
		next_col = sel_ext ? upd_col : core_column_out;
		next_ped = sel_pre ? upd_ped : pedestal_in_bus;
		next_inj = sel_pre ? bsr_upd[BSR_INJ] : cfg_latch[CFG_INJ_BIT];
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ir                 <= IR_IDCODE;
			bsr_upd            <= '0;
			cfg_latch          <= '0;
			test_data_out      <= 1'b0;
			test_data_out_oe   <= 1'b0;
			channel_chain_load <= 1'b0;
			column_out_bus     <= '0;
			core_pedestal_in   <= '0;
			test_inject_enable <= 1'b0;
		end
		else
		begin
			ir                 <= next_ir;
			bsr_upd            <= next_bsr_upd;
			cfg_latch          <= next_cfg_latch;
			test_data_out      <= next_tdo;
			test_data_out_oe   <= next_tdo_oe;
			channel_chain_load <= next_chan_load;
			column_out_bus     <= next_col;
			core_pedestal_in   <= next_ped;
			test_inject_enable <= next_inj;
		end
	end

	assign config_bits = cfg_latch;

	// Checks
	logic [2:0] ms_high;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ms_high <= '0;
		else if (tck_rise)
			ms_high <= tms ? ((ms_high == 3'(MS_FIVE)) ? ms_high
				: ms_high + 3'h1) : 3'h0;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence cfg_update_s;
		upd_dr_hit && sel_cfg && test_reset_low;
	endsequence
	sequence std_shift_s;
		dr_shift_r && sel_byp && test_reset_low;
	endsequence

	tap_hold_a: assert property (!tck_rise && test_reset_low
		##1 test_reset_low |-> tap_state == $past(tap_state))
		else $error("tap moved without a rising test clock");
	tap_async_a: assert property (!test_reset_low |->
		tap_state == TAP_RESET)
		else $error("tap not held in reset");
	chain_keep_a: assert property (!test_reset_low && !dr_shift_f
		|=> cfg_chain == $past(cfg_chain))
		else $error("test reset disturbed config chain");
	ir_load_a: assert property (upd_ir_hit && test_reset_low
		|=> ir == $past(ir_chain))
		else $error("instruction not loaded on update");
	pad_drive_a: assert property (sel_ext ##1 sel_ext |->
		column_out_bus == $past(upd_col))
		else $error("output pads not driven from update cells");
	core_drive_a: assert property (sel_pre ##1 sel_pre |->
		core_pedestal_in == $past(upd_ped))
		else $error("core inputs not driven from update cells");
	bypass_one_a: assert property (std_shift_s |=>
		u_byp.chain == $past(tdi))
		else $error("bypass stage did not take test data in");
	cfg_latch_a: assert property (cfg_update_s |=>
		config_bits == $past(cfg_chain))
		else $error("config latches missed update");
	tdo_rise_a: assert property (tck_fall && (sel_cfg || sel_chan)
		&& tap_state != TAP_SH_IR
		|=> test_data_out == $past(test_data_out))
		else $error("config data out moved on falling edge");
	five_high_a: assert property (ms_high == 3'(MS_FIVE)
		&& test_reset_low |-> tap_state == TAP_RESET)
		else $error("five high mode selects did not reset tap");
endmodule
`default_nettype wire

// *** sim/jcbp_host.sv ***
// Behavioural serial test controller for the test access port
`timescale 1ns/10ps
`default_nettype none
module jcbp_host (
	// Serial test link
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_low,
	input  wire logic tdo
);
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_low = 1'b1;
	end

	// Clock stands low between frames; index i: tms, tdi, tdo of cycle i
	task automatic frame(input int n, input logic [255:0] ms,
		input logic [255:0] di, input bit cfg, output logic [255:0] dq);
		dq = '0;
		#3;
		for (int i = 0; i < n; i++)
		begin
			tck = 1'b0;
			tms = ms[i];
			if (!cfg)
				tdi = di[i];
			#75;
			if (cfg)
				dq[i] = tdo;
			#5 tck = 1'b1;
			// Falling-edge chains need data steady across the fall
			if (cfg)
				tdi = di[i + 1];
			#75;
			if (!cfg)
				dq[i] = tdo;
			#5;
		end
		tck = 1'b0;
		// Released data line shows the inverse, not the last bit
		tdi = ~tdi;
	endtask

	task automatic pulse_reset();
		trst_low = 1'b0;
		#100;
		trst_low = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** sim/jtag_config_boundary_port_test.sv ***
// Self-checking bench for the test access port
`timescale 1ns/10ps
`default_nettype none
module jtag_config_boundary_port_test;
	import jcbp_pkg::*;
	localparam int CH = 16;
	// Arbitrary identification value
	localparam logic [ID_W-1:0] TB_ID = 32'h5e17_c0a3;
	logic                 clk_sys = 1'b0;
	logic                 rst = 1'b1;
	logic [COL_OUT_W-1:0] core_column_out = 64'h0123_4567_89ab_cdef;
	logic                 core_echoed_fast_clock = 1'b1;
	logic [PED_W-1:0]     pedestal_in_bus = 16'h9c3a;
	logic                 pad_fast_clock = 1'b0;
	logic                 pad_sync_reset = 1'b1;
	logic                 tck, tms, tdi, trst_low, tdo, tdo_oe;
	logic [COL_OUT_W-1:0] column_out_bus;
	logic [PED_W-1:0]     core_pedestal_in;
	logic                 test_inject_enable;
	logic [CFG_LEN-1:0]   config_bits;
	logic [CH-1:0]        channel_chain;
	logic                 channel_chain_load;
	int                   errors = 0;
	int                   total_checks = 0;
	int                   loads = 0;
	int                   oe_cycles = 0;

	always #10 clk_sys = ~clk_sys;

	always @(posedge clk_sys)
		if (tdo_oe === 1'b1)
			oe_cycles <= oe_cycles + 1;

	always @(posedge clk_sys)
		if (channel_chain_load === 1'b1)
			loads <= loads + 1;

	jcbp_port #(
		.CHAN_BITS(CH),
		.ID_CODE  (TB_ID)
	) u_dut (
		.clk_sys, .rst,
		.test_clock(tck), .test_mode_select(tms),
		.test_data_in(tdi), .test_reset_low(trst_low),
		.test_data_out(tdo), .test_data_out_oe(tdo_oe),
		.core_column_out, .core_echoed_fast_clock, .column_out_bus,
		.pedestal_in_bus, .pad_fast_clock, .pad_sync_reset,
		.core_pedestal_in, .test_inject_enable,
		.config_bits, .channel_chain, .channel_chain_load
	);

	jcbp_host u_host (
		.tck, .tms, .tdi, .trst_low, .tdo
	);

	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("errors %0d checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic [255:0] rev(input logic [255:0] v, input int n);
		logic [255:0] r;
		r = '0;
		for (int i = 0; i < n; i++)
			r[n - 1 - i] = v[i];
		return r;
	endfunction

	task automatic idle();
		logic [255:0] q;
		u_host.frame(6, 256'h1f, '0, 1'b0, q);
	endtask

	// Instruction scan from idle, code LSB first; returns captured bits
	task automatic ir(input logic [3:0] code, output logic [3:0] cap);
		logic [255:0] q;
		u_host.frame(10, 256'h183, 256'(code) << 4, 1'b0, q);
		cap = q[7:4];
	endtask

	// Data scan of n bits from idle back to idle; bit k out at q[k]
	task automatic dr(input int n, input logic [255:0] d, input bit cfg,
		output logic [255:0] q);
		logic [255:0] ms;
		ms = '0;
		ms[0] = 1'b1;
		ms[n + 2] = 1'b1;
		ms[n + 3] = 1'b1;
		u_host.frame(n + 5, ms, d << 3, cfg, q);
		q = (q >> 3) & ((256'b1 << n) - 1);
	endtask

	task automatic t_idcode();
		logic [255:0] q;
		int           oe0;
		oe0 = oe_cycles;
		dr(32, '0, 1'b0, q);
		check(q, TB_ID);
		// Enable stands for 32 link periods of 8 system clocks each
		check(oe_cycles - oe0, 32 * 160 / 20);
		check(tdo_oe, 1'b0);
	endtask

	task automatic t_bypass();
		logic [3:0]   c;
		logic [255:0] q;
		logic [3:0]   codes [3];
		codes = '{IR_BYPASS, 4'h3, 4'hc};
		foreach (codes[i])
		begin
			ir(codes[i], c);
			check(c, IR_CAPTURE);
			dr(9, 9'h0b4, 1'b0, q);
			check(q, {8'hb4, 1'b0});
		end
	endtask

	task automatic t_bscan(input logic [3:0] code, input logic [83:0] s);
		logic [255:0] q, e, m;
		logic [63:0]  col;
		logic [15:0]  ped;
		logic [3:0]   c;
		int           b;
		@(posedge clk_sys);
		core_column_out <= ~core_column_out;
		pedestal_in_bus <= ~pedestal_in_bus;
		core_echoed_fast_clock <= ~core_echoed_fast_clock;
		pad_fast_clock <= ~pad_fast_clock;
		pad_sync_reset <= ~pad_sync_reset;
		ir(code, c);
		dr(84, s, 1'b0, q);
		e = '0;
		m = (256'b1 << 84) - 1;
		m[40] = 1'b0;
		for (int p = 0; p < 8; p++)
		begin
			b = (p >= 4) ? (7 - p) * 10 : 44 + (3 - p) * 10;
			e[b +: 2] = pedestal_in_bus[p * 2 +: 2];
			e[b + 2 +: 8] = core_column_out[p * 8 +: 8];
			ped[p * 2 +: 2] = s[b +: 2];
			col[p * 8 +: 8] = s[b + 2 +: 8];
		end
		e[41] = core_echoed_fast_clock;
		e[42] = pad_fast_clock;
		e[43] = pad_sync_reset;
		check(q & m, e);
		if (code == IR_EXTEST)
		begin
			check(column_out_bus, col);
			check(core_pedestal_in, pedestal_in_bus);
		end
		else
		begin
			check(core_pedestal_in, ped);
			check(test_inject_enable, s[40]);
			check(column_out_bus, core_column_out);
		end
	endtask

	task automatic t_config();
		logic [255:0] q, p1;
		logic [3:0]   c;
		p1 = 256'({15{16'h1e6b}});
		ir(IR_CONFIG, c);
		dr(CFG_LEN, p1, 1'b1, q);
		check(config_bits, rev(p1, CFG_LEN));
		check(test_inject_enable, p1[CFG_LEN - 1 - CFG_INJ_BIT]);
		dr(CFG_LEN, ~p1, 1'b1, q);
		check(q, p1);
		u_host.pulse_reset();
		check(config_bits, rev(~p1, CFG_LEN));
		idle();
		t_idcode();
	endtask

	task automatic t_five_high();
		logic [255:0] q;
		logic [3:0]   c;
		ir(IR_BYPASS, c);
		// Stop in the shift state, then five high mode-select edges
		u_host.frame(9, 256'h0f9, '0, 1'b0, q);
		t_idcode();
	endtask

	task automatic t_channel();
		logic [255:0] q;
		logic [3:0]   c;
		ir(IR_CHANNEL, c);
		dr(CH, 16'h3c96, 1'b1, q);
		check(channel_chain, rev(16'h3c96, CH));
		check(loads, 1);
		dr(CH, 16'h0ff0, 1'b1, q);
		check(q, 16'h3c96);
		check(loads, 2);
	endtask

	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		idle();
		t_idcode();
		t_bypass();
		t_bscan(IR_EXTEST, 84'h9_3c5a_0f1e_d2b4_7786_c1e9);
		t_bscan(IR_SAMPLE, 84'h6_c3a5_f0e1_2d4b_8879_3e16);
		t_config();
		t_five_high();
		t_channel();
		final_report();
	end
endmodule
`default_nettype wire
